/* File: src/amp_diag_pkg.sv */
// Package: register offsets, field positions and reset values for the
// alert mask and AC diagnostic register slice.
// Assumes an 8-bit register port decoded by the device's control bus.
package amp_diag_pkg;
    localparam logic [7:0] OFS_WARN_STATUS = 8'h13; // Warning status
    localparam logic [7:0] OFS_ALERT_MASKS = 8'h14; // Alert output masks
    localparam logic [7:0] OFS_AC_CTRL_ONE = 8'h15; // AC control one
    localparam logic [7:0] OFS_AC_CTRL_TWO = 8'h16; // AC control two
    localparam logic [7:0] OFS_IMP_CH1 = 8'h17; // Impedance ch1
    localparam logic [7:0] OFS_IMP_CH2 = 8'h18; // Impedance ch2
    localparam logic [7:0] OFS_PHASE_UP = 8'h1b; // Phase bits 15:8
    localparam logic [7:0] OFS_PHASE_LO = 8'h1c; // Phase bits 7:0
    localparam logic [7:0] OFS_STI_UP = 8'h1d; // STI bits 15:8
    localparam logic [7:0] OFS_STI_LO = 8'h1e; // STI bits 7:0
    // Warning status bit positions
    localparam int unsigned B_OTW_GLOBAL = 4;
    localparam int unsigned B_OVERHEAT_WARNING_CHAN_ONE = 3;
    localparam int unsigned B_OVERHEAT_WARNING_CHAN_TWO = 2;
    // Alert mask bit positions
    localparam int unsigned B_M_OC = 7;
    localparam int unsigned B_M_OTSD = 6;
    localparam int unsigned B_M_UV = 5;
    localparam int unsigned B_M_OV = 4;
    localparam int unsigned B_M_DC = 3;
    localparam int unsigned B_M_ILIM = 2;
    localparam int unsigned B_M_CLIP = 1;
    localparam int unsigned B_M_OTW = 0;
    // AC control one / two writable bits; reserved bits read zero
    localparam logic [7:0] AC_ONE_WMASK = 8'h8c; // Gain, ch1, ch2 enables
    localparam logic [7:0] AC_TWO_WMASK = 8'h9c; // Loop, timing, current
    localparam int unsigned B_AC_GAIN = 7;
    localparam int unsigned B_AC_EN1 = 3;
    localparam int unsigned B_AC_EN2 = 2;
    localparam int unsigned B_AC_LOOP = 7;
    localparam int unsigned B_AC_TEST_CYCLE_COUNT = 4;
    localparam int unsigned B_AC_CUR_HI = 3;
    localparam int unsigned B_AC_CUR_LO = 2;
    // Reset values
    localparam logic [7:0] RST_MASKS = 8'h00;
    localparam logic [7:0] RST_AC = 8'h00;
    localparam logic [7:0] RST_RESULT = 8'h00;
    // Measurement lengths selected by the timing bit
    localparam logic [6:0] AC_CYCLES_SHORT = 7'h20; // 32 cycles
    localparam logic [6:0] AC_CYCLES_LONG = 7'h40; // 64 cycles
endpackage

/* File: src/amp_diag_regs.sv */
// Alert mask and AC load diagnostic register slice of the amplifier.
// Assumes a decoded 8-bit register port from the control bus (write
// strobe, read strobe, address, data), fault levels from the protection
// logic and result words from the AC measurement engine.
//
// Summary of operation
// (R01) Global overheat warning readable at bit four
// (R02) Channel overheat warnings at bits three, two
// (R03) Mask bit seven hides overcurrent from error
// (R04) Mask bit six hides thermal shutdown
// (R05) Mask bit five hides undervoltage
// (R06) Mask bit four hides overvoltage
// (R07) Mask bit three hides DC offset
// (R08) Mask bit two hides current limit
// (R09) Mask bit one hides clipping from caution
// (R10) Mask bit zero hides overheat warning caution
// (R11) Mask register at 0x14, resets to zero
// (R12) Control one bit seven selects gain four
// (R13) Control one bits three, two enable channels
// (R14) Control two bit seven enables loopback
// (R15) Control two bit four selects 64 cycles
// (R16) Control two bits 3-2 select test current
// (R17) Impedance codes per channel at 0x17, 0x18
// (R18) Phase result split over 0x1b, 0x1c
// (R19) STI result split over 0x1d, 0x1e
// (R20) Reserved bits read zero
//
// Port timing, seen from the host side:
// - A write strobe is taken at the rising edge where it stands; the
//   register holds the new value from the next cycle on.
// - A read strobe is answered one cycle later by a one-cycle valid
//   pulse; the read data stays put until the next read.
// - A read and a write in the same cycle return the old contents.
// - Writes to status, result or unmapped offsets change nothing.
// - The 16-bit results have no lock: an update between reading the
//   two halves can tear the word, so hosts read them back to back.
// - Alert pins are registered, one cycle behind their sources, and
//   idle high; masks only gate, they never latch a fault.
// - Reserved current codes are stored as written; software keeps
//   them out, this slice does not police them.
module amp_diag_regs
    import amp_diag_pkg::*;
(
    input wire logic clk_sys, // 25 MHz system clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic reg_wr, // One-cycle write strobe
    input wire logic reg_rd, // One-cycle read strobe
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, held after a read
    output logic reg_rvalid, // Read data valid pulse
    input wire logic overheat_warning_global, // Device warning level
    input wire logic overheat_warning_chan_one, // Ch1 warning level
    input wire logic overheat_warning_chan_two, // Ch2 warning level
    input wire logic fault_overcurrent, // Any overcurrent fault
    input wire logic fault_thermal_shutdown, // Any thermal shutdown
    input wire logic fault_low_supply, // Any undervoltage fault
    input wire logic fault_high_supply, // Any overvoltage fault
    input wire logic fault_dc_offset, // Any DC offset fault
    input wire logic event_current_limit, // Any current-limit event
    input wire logic event_clipping, // Any clipping event
    input wire logic result_update, // Engine results valid pulse
    input wire logic [7:0] result_imp_ch1, // Ch1 impedance code
    input wire logic [7:0] result_imp_ch2, // Ch2 impedance code
    input wire logic [15:0] result_phase, // Phase word
    input wire logic [15:0] result_sti, // STI word
    output logic error_alert_n, // Error alert, low when active
    output logic caution_alert_n, // Caution alert, low when active
    output logic ac_gain_four, // Diagnostic gain four selected
    output logic ac_test_on_chan_one, // Ch1 AC test enabled
    output logic ac_test_on_chan_two, // Ch2 AC test enabled
    output logic ac_test_self_return, // Loopback mode
    output logic [6:0] ac_test_cycle_count, // 32 or 64 cycles
    output logic [1:0] ac_test_drive_level // Test current code
);

    // Whole block state in one record
    typedef struct packed {
        logic [7:0] masks; // Alert output masks
        logic [7:0] ac_one; // AC control one
        logic [7:0] ac_two; // AC control two
        logic [7:0] warn; // Warning status snapshot
        logic [7:0] imp1; // Impedance ch1
        logic [7:0] imp2; // Impedance ch2
        logic [15:0] phase; // Phase result
        logic [15:0] sti; // STI result
        logic [7:0] rdata; // Read data holding register
        logic rvalid; // Read answer pulse
        logic err_n; // Error alert pin
        logic cau_n; // Caution alert pin
    } state_t;

    state_t st_r; // Registered state
    state_t st_nxt; // Next state
    logic err_any; // Unmasked error source present
    logic cau_any; // Unmasked caution source present
    logic otw_any; // Any overheat warning

    // Alert gating: a zero mask bit lets the source through
    always_comb begin
        otw_any = overheat_warning_global | overheat_warning_chan_one
                | overheat_warning_chan_two;
        err_any = (fault_overcurrent & ~st_r.masks[B_M_OC]) // [R03]
                | (fault_thermal_shutdown & ~st_r.masks[B_M_OTSD]) // [R04]
                | (fault_low_supply & ~st_r.masks[B_M_UV]) // [R05]
                | (fault_high_supply & ~st_r.masks[B_M_OV]) // [R06]
                | (fault_dc_offset & ~st_r.masks[B_M_DC]) // [R07]
                | (event_current_limit & ~st_r.masks[B_M_ILIM]); // [R08]
        cau_any = (event_clipping & ~st_r.masks[B_M_CLIP]) // [R09]
                | (otw_any & ~st_r.masks[B_M_OTW]); // [R10]
    end

    // Next-state logic: writes, result capture, read mux, pins
    always_comb begin
        st_nxt = st_r;
        // Warnings follow their sources, other bits zero
        st_nxt.warn = 8'h00;
        st_nxt.warn[B_OTW_GLOBAL] = overheat_warning_global; // [R01]
        st_nxt.warn[B_OVERHEAT_WARNING_CHAN_ONE] = overheat_warning_chan_one; // [R02]
        st_nxt.warn[B_OVERHEAT_WARNING_CHAN_TWO] = overheat_warning_chan_two; // [R02]
        // Pins are registered, so alerts lag the source one cycle
        st_nxt.err_n = ~err_any;
        st_nxt.cau_n = ~cau_any;
        // Results replace as a set, so both halves of a word agree
        if (result_update) begin
            st_nxt.imp1 = result_imp_ch1; // [R17]
            st_nxt.imp2 = result_imp_ch2; // [R17]
            st_nxt.phase = result_phase; // [R18]
            st_nxt.sti = result_sti; // [R19]
        end
        // Register writes; read-only offsets ignore writes
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_ALERT_MASKS: begin
                    st_nxt.masks = reg_wdata; // [R11]
                end
                OFS_AC_CTRL_ONE: begin
                    // Reserved bits kept zero
                    st_nxt.ac_one = reg_wdata & AC_ONE_WMASK; // [R20]
                end
                OFS_AC_CTRL_TWO: begin
                    // Reserved current codes stored as written
                    st_nxt.ac_two = reg_wdata & AC_TWO_WMASK; // [R20]
                end
                default: begin
                    // Unmapped or read-only: ignored
                end
            endcase
        end
        // Read answer one cycle after the strobe
        st_nxt.rvalid = reg_rd;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_WARN_STATUS: st_nxt.rdata = st_r.warn; // [R01]
                OFS_ALERT_MASKS: st_nxt.rdata = st_r.masks; // [R11]
                OFS_AC_CTRL_ONE: st_nxt.rdata = st_r.ac_one; // [R13]
                OFS_AC_CTRL_TWO: st_nxt.rdata = st_r.ac_two; // [R16]
                OFS_IMP_CH1: st_nxt.rdata = st_r.imp1; // [R17]
                OFS_IMP_CH2: st_nxt.rdata = st_r.imp2; // [R17]
                OFS_PHASE_UP: st_nxt.rdata = st_r.phase[15:8]; // [R18]
                OFS_PHASE_LO: st_nxt.rdata = st_r.phase[7:0]; // [R18]
                OFS_STI_UP: st_nxt.rdata = st_r.sti[15:8]; // [R19]
                OFS_STI_LO: st_nxt.rdata = st_r.sti[7:0]; // [R19]
                default: st_nxt.rdata = 8'h00; // Unmapped reads zero
            endcase
        end
    end

    // State register; alerts idle high during reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.masks <= RST_MASKS; // [R11]
            st_r.ac_one <= RST_AC;
            st_r.ac_two <= RST_AC;
            st_r.imp1 <= RST_RESULT;
            st_r.imp2 <= RST_RESULT;
            st_r.err_n <= 1'b1;
            st_r.cau_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state flip-flops
    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign error_alert_n = st_r.err_n;
    assign caution_alert_n = st_r.cau_n;
    assign ac_gain_four = st_r.ac_one[B_AC_GAIN]; // [R12]
    assign ac_test_on_chan_one = st_r.ac_one[B_AC_EN1]; // [R13]
    assign ac_test_on_chan_two = st_r.ac_one[B_AC_EN2]; // [R13]
    assign ac_test_self_return = st_r.ac_two[B_AC_LOOP]; // [R14]
    // Length decoded from one stored bit, still flop-driven
    assign ac_test_cycle_count = st_r.ac_two[B_AC_TEST_CYCLE_COUNT] ?
        AC_CYCLES_LONG : AC_CYCLES_SHORT; // [R15]
    assign ac_test_drive_level =
        st_r.ac_two[B_AC_CUR_HI:B_AC_CUR_LO]; // [R16]

    // Checks, all on the system clock and idle during reset

    // Unmasked overcurrent pulls the error pin next cycle
    overcur_alert_a: assert property (@(posedge clk_sys) // [R03]
        disable iff (!nrst)
        fault_overcurrent && !st_r.masks[B_M_OC] |=> !error_alert_n)
        else $error("Unmasked overcurrent did not raise error alert");

    // Unmasked thermal shutdown pulls the error pin
    thermal_alert_a: assert property (@(posedge clk_sys) // [R04]
        disable iff (!nrst)
        fault_thermal_shutdown && !st_r.masks[B_M_OTSD] |=> !error_alert_n)
        else $error("Unmasked thermal shutdown missed");

    // All six error masks set keep the error pin idle
    error_quiet_a: assert property (@(posedge clk_sys) // [R05]
        disable iff (!nrst)
        (st_r.masks[7:2] == 6'h3f) |=> error_alert_n)
        else $error("Error alert with all sources masked");

    // Unmasked undervoltage pulls the error pin
    lowsup_alert_a: assert property (@(posedge clk_sys) // [R05]
        disable iff (!nrst)
        fault_low_supply && !st_r.masks[B_M_UV] |=> !error_alert_n)
        else $error("Unmasked undervoltage missed");

    // Unmasked overvoltage pulls the error pin
    overvolt_alert_a: assert property (@(posedge clk_sys) // [R06]
        disable iff (!nrst)
        fault_high_supply && !st_r.masks[B_M_OV] |=> !error_alert_n)
        else $error("Unmasked overvoltage missed");

    // Unmasked DC offset pulls the error pin
    dc_alert_a: assert property (@(posedge clk_sys) // [R07]
        disable iff (!nrst)
        fault_dc_offset && !st_r.masks[B_M_DC] |=> !error_alert_n)
        else $error("Unmasked DC offset missed");

    // Unmasked current limit pulls the error pin
    ilim_alert_a: assert property (@(posedge clk_sys) // [R08]
        disable iff (!nrst)
        event_current_limit && !st_r.masks[B_M_ILIM] |=> !error_alert_n)
        else $error("Unmasked current limit missed");

    // Unmasked clipping pulls the caution pin
    clip_caution_a: assert property (@(posedge clk_sys) // [R09]
        disable iff (!nrst)
        event_clipping && !st_r.masks[B_M_CLIP] |=> !caution_alert_n)
        else $error("Unmasked clipping missed");

    // Both caution masks set keep the caution pin idle
    caution_quiet_a: assert property (@(posedge clk_sys) // [R10]
        disable iff (!nrst)
        (st_r.masks[1:0] == 2'b11) |=> caution_alert_n)
        else $error("Caution alert with all sources masked");

    // Any unmasked overheat warning pulls the caution pin
    otw_caution_a: assert property (@(posedge clk_sys) // [R10]
        disable iff (!nrst)
        otw_any && !st_r.masks[B_M_OTW] |=> !caution_alert_n)
        else $error("Unmasked overheat warning missed");

    // Mask writes land whole in the next cycle
    mask_write_a: assert property (@(posedge clk_sys) // [R11]
        disable iff (!nrst)
        reg_wr && reg_addr == OFS_ALERT_MASKS |=>
        st_r.masks == $past(reg_wdata))
        else $error("Mask register write lost");

    // Read answer is exactly one cycle behind its strobe
    read_answer_a: assert property (@(posedge clk_sys) // [R11]
        disable iff (!nrst)
        $past(nrst) |-> reg_rvalid == $past(reg_rd))
        else $error("Read valid pulse out of step");

    // Global warning bit tracks its source one cycle late
    warn_global_a: assert property (@(posedge clk_sys) // [R01]
        disable iff (!nrst)
        $past(nrst) |->
        st_r.warn[B_OTW_GLOBAL] == $past(overheat_warning_global))
        else $error("Global warning bit out of step");

    // Channel warning bits track their sources
    warn_chan_a: assert property (@(posedge clk_sys) // [R02]
        disable iff (!nrst)
        $past(nrst) |->
        st_r.warn[B_OVERHEAT_WARNING_CHAN_ONE] == $past(overheat_warning_chan_one) &&
        st_r.warn[B_OVERHEAT_WARNING_CHAN_TWO] == $past(overheat_warning_chan_two))
        else $error("Channel warning bits out of step");

    // Warning reads never show reserved bits
    warn_read_a: assert property (@(posedge clk_sys) // [R20]
        disable iff (!nrst)
        reg_rd && reg_addr == OFS_WARN_STATUS |=>
        reg_rvalid && reg_rdata[7:5] == 3'h0 && reg_rdata[1:0] == 2'h0)
        else $error("Warning read shows reserved bits");

    // Control registers never hold reserved ones
    ctrl_reserved_a: assert property (@(posedge clk_sys) // [R20]
        disable iff (!nrst)
        (st_r.ac_one & ~AC_ONE_WMASK) == 8'h00 &&
        (st_r.ac_two & ~AC_TWO_WMASK) == 8'h00)
        else $error("Reserved control bit set");

    // Gain bit written as one selects gain four
    gain_on_a: assert property (@(posedge clk_sys) // [R12]
        disable iff (!nrst)
        reg_wr && reg_addr == OFS_AC_CTRL_ONE && reg_wdata[B_AC_GAIN]
        |=> ac_gain_four)
        else $error("Gain bit did not select gain four");

    // Channel one enable written as one switches it on
    chan_one_on_a: assert property (@(posedge clk_sys) // [R13]
        disable iff (!nrst)
        reg_wr && reg_addr == OFS_AC_CTRL_ONE && reg_wdata[B_AC_EN1]
        |=> ac_test_on_chan_one)
        else $error("Channel one test not enabled");

    // Channel two enable written as zero switches it off
    chan_two_off_a: assert property (@(posedge clk_sys) // [R13]
        disable iff (!nrst)
        reg_wr && reg_addr == OFS_AC_CTRL_ONE && !reg_wdata[B_AC_EN2]
        |=> !ac_test_on_chan_two)
        else $error("Channel two test not disabled");

    // Loopback bit written as one turns loopback on
    loop_on_a: assert property (@(posedge clk_sys) // [R14]
        disable iff (!nrst)
        reg_wr && reg_addr == OFS_AC_CTRL_TWO && reg_wdata[B_AC_LOOP]
        |=> ac_test_self_return)
        else $error("Loopback not enabled");

    // Timing bit one selects the long measurement
    timing_sel_a: assert property (@(posedge clk_sys) // [R15]
        disable iff (!nrst)
        reg_wr && reg_addr == OFS_AC_CTRL_TWO && reg_wdata[B_AC_TEST_CYCLE_COUNT]
        |=> ac_test_cycle_count == AC_CYCLES_LONG)
        else $error("Timing bit did not select 64 cycles");

    // Timing bit zero selects the short measurement
    timing_short_a: assert property (@(posedge clk_sys) // [R15]
        disable iff (!nrst)
        reg_wr && reg_addr == OFS_AC_CTRL_TWO && !reg_wdata[B_AC_TEST_CYCLE_COUNT]
        |=> ac_test_cycle_count == AC_CYCLES_SHORT)
        else $error("Timing bit did not select 32 cycles");

    // Current code 01 reaches the drive level output
    drive_level_a: assert property (@(posedge clk_sys) // [R16]
        disable iff (!nrst)
        reg_wr && reg_addr == OFS_AC_CTRL_TWO &&
        reg_wdata[B_AC_CUR_HI:B_AC_CUR_LO] == 2'b01
        |=> ac_test_drive_level == 2'b01)
        else $error("Test current code not applied");

    // Impedance codes captured on the update pulse
    imp_capture_a: assert property (@(posedge clk_sys) // [R17]
        disable iff (!nrst)
        result_update |=> st_r.imp1 == $past(result_imp_ch1) &&
        st_r.imp2 == $past(result_imp_ch2))
        else $error("Impedance result not captured");

    // Upper phase byte read returns the stored word
    phase_read_a: assert property (@(posedge clk_sys) // [R18]
        disable iff (!nrst)
        reg_rd && reg_addr == OFS_PHASE_UP && !result_update
        |=> reg_rdata == st_r.phase[15:8])
        else $error("Phase upper byte read mismatch");

    // STI word captured on the update pulse
    sti_capture_a: assert property (@(posedge clk_sys) // [R19]
        disable iff (!nrst)
        result_update |=> st_r.sti == $past(result_sti))
        else $error("STI result not captured");
endmodule

/* File: bench/host_model.sv */
// Host side of the register port: write and read cycles on request.
// Assumes one clock; tasks are called from the bench by hierarchy.
module host_model (
    input wire logic clk_sys,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle port at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One-cycle write; idle bus shows inverted values, not stale ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // One-cycle read; data taken while the valid pulse stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        n = 0;
        // Bounded wait so a lost pulse cannot hang the run
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
endmodule

/* File: bench/tb_amp_diag_regs.sv */
// Self-checking bench for the alert mask and AC diagnostic registers.
// Assumes host_model on the register port; bench drives all sources.
module tb_amp_diag_regs;
    import amp_diag_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    // Sources: glob, ch1, ch2, oc, otsd, uv, ov, dc, ilim, clip
    logic [9:0] src = 10'h000;
    logic upd = 1'b0;
    logic [7:0] i1 = 8'h00, i2 = 8'h00, m, e, r;
    logic [15:0] ph = 16'h0000, st = 16'h0000, seed = 16'd7915;
    logic err_n, cau_n, gain4, en1, en2, loopb;
    logic [6:0] cyc;
    logic [1:0] drv;
    logic [7:0] al [12] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
                            8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h19, 8'hff};
    int n_errors = 0;
    int comparisons = 0;
    // 40 ns period
    always #20 clk_sys = ~clk_sys;
    host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    amp_diag_regs dut (.clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .overheat_warning_global(src[9]), .overheat_warning_chan_one(src[8]),
        .overheat_warning_chan_two(src[7]), .fault_overcurrent(src[6]),
        .fault_thermal_shutdown(src[5]), .fault_low_supply(src[4]),
        .fault_high_supply(src[3]), .fault_dc_offset(src[2]),
        .event_current_limit(src[1]), .event_clipping(src[0]),
        .result_update(upd), .result_imp_ch1(i1), .result_imp_ch2(i2),
        .result_phase(ph), .result_sti(st), .error_alert_n(err_n),
        .caution_alert_n(cau_n), .ac_gain_four(gain4),
        .ac_test_on_chan_one(en1), .ac_test_on_chan_two(en2),
        .ac_test_self_return(loopb), .ac_test_cycle_count(cyc),
        .ac_test_drive_level(drv));
    // Pseudo-random step, fixed start for repeatable runs
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected {error_n, caution_n}; any warning feeds caution
    function automatic logic [1:0] alerts(input logic [7:0] mk,
                                          input logic [9:0] s);
        logic er, ca;
        er = |(s[6:1] & ~mk[7:2]);
        ca = (s[0] & ~mk[1]) | ((|s[9:7]) & ~mk[0]);
        return {~er, ~ca};
    endfunction
    // Single comparison point
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Counts, verdict, end of run
    task automatic end_sim;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        #2000000;
        n_errors++;
        end_sim();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        // Reset values, read-only and unmapped places read zero
        for (int k = 0; k < 12; k++) begin
            host.rd(al[k], r);
            chk(r, 8'h00);
        end
        chk({err_n, cau_n, cyc}, {2'b11, 7'h20});
        // Masks against sources; first two passes are corners
        for (int k = 0; k < 40; k++) begin
            seed = lfsr(seed);
            m = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : seed[7:0];
            host.wr(OFS_ALERT_MASKS, m);
            seed = lfsr(seed);
            @(posedge clk_sys);
            src <= (k < 2) ? 10'h3ff : seed[9:0];
            repeat (2) @(posedge clk_sys);
            #1;
            e[1:0] = alerts(m, src);
            chk(err_n, e[1]);
            chk(cau_n, e[0]);
            host.rd(OFS_ALERT_MASKS, r);
            chk(r, m);
            host.rd(OFS_WARN_STATUS, r);
            chk(r, {3'b000, src[9:7], 2'b00});
        end
        // Control registers; reserved bits written with random values on purpose
        for (int k = 0; k < 20; k++) begin
            seed = lfsr(seed);
            m = seed[7:0];
            // Host keeps the current code to 00 or 01
            e = {seed[15:12], 1'b0, seed[10:8]};
            host.wr(OFS_AC_CTRL_ONE, m);
            host.wr(OFS_AC_CTRL_TWO, e);
            host.rd(OFS_AC_CTRL_ONE, r);
            chk(r, m & 8'h8c);
            host.rd(OFS_AC_CTRL_TWO, r);
            chk(r, e & 8'h9c);
            chk({gain4, en1, en2}, {m[7], m[3], m[2]});
            chk(loopb, e[7]);
            chk(cyc, e[4] ? 7'h40 : 7'h20);
            chk(drv, e[3:2]);
        end
        // Result capture; a write to the ch1 impedance place is ignored
        for (int k = 0; k < 10; k++) begin
            seed = lfsr(seed);
            @(posedge clk_sys);
            upd <= 1'b1;
            i1 <= seed[7:0];
            i2 <= seed[15:8];
            ph <= lfsr(seed);
            st <= ~seed;
            @(posedge clk_sys);
            upd <= 1'b0;
            host.wr(OFS_IMP_CH1, ~i1);
            host.rd(OFS_IMP_CH1, r);
            chk(r, i1);
            host.rd(OFS_IMP_CH2, r);
            chk(r, i2);
            host.rd(OFS_PHASE_UP, r);
            chk(r, ph[15:8]);
            host.rd(OFS_PHASE_LO, r);
            chk(r, ph[7:0]);
            host.rd(OFS_STI_UP, r);
            chk(r, st[15:8]);
            host.rd(OFS_STI_LO, r);
            chk(r, st[7:0]);
        end
        end_sim();
    end
endmodule
